// [tsw_core.sv]
// TDM channel switch core: stream engines, switching memories, test sequences, reference watch
//
// Behaviour
// - Connection slots output the data memory byte of the source stream and channel.
// - Message slots output the connection memory byte in place of switched data.
// - Test slots output bytes from one of 32 independent 2^15-1 sequence generators.
// - Any input channel can feed any of 32 sequence error detectors.
// - High impedance slots leave the output undriven for that timeslot.
// - In bidirectional mode inputs come from the output stream pins, not dedicated inputs.
// - Each input and output stream has its own rate of 2, 4, 8 or 16 Mbps.
// - Tristate control outputs exist only for output streams 0 to 15.
// - Any channel of any input reaches any output channel without blocking.
// - As timing master, bit timing comes from the internal loop, not external pins.
// - The loop locks to one of four timing references.
// - Loop timing modes are normal, holdover and freerun.
// - Automatic mode with preference switches only between two consecutive references.
// - Host reads and writes connection memory, reads data memory, never writes it.
// - Host strobes follow one of two selectable bus conventions.
// - Failed references raise their failure output in master mode; low in slave mode unless enabled.
`timescale 1ns/1ps
`include "tsw_regs.svh"
module tsw_core import tsw_pkg::*; #(
  parameter int REF_LOSS_CYCLES = `TSW_REF_LOSS_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [31:0] serial_input_stream,
  input wire logic [31:0] serial_output_stream_in,
  output logic [31:0] serial_output_stream_out,
  output logic [31:0] serial_output_stream_oe,
  output logic [15:0] stream_tristate_control,
  input wire logic bidir_mode,
  input wire logic [63:0] in_rate,
  input wire logic [63:0] out_rate,
  input wire logic master_mode,
  input wire logic pll_bit_tick,
  input wire logic pll_frame_start,
  input wire logic ext_bit_clk,
  input wire logic ext_frame_pulse,
  input wire logic [3:0] timing_reference_inputs,
  output logic [3:0] reference_failure_outputs,
  input wire logic slave_pll_enable,
  input wire logic [1:0] timing_mode,
  input wire logic [1:0] ref_pref,
  input wire logic fast_lock,
  output logic [1:0] pll_ref_sel,
  output logic pll_ref_level,
  output logic [1:0] pll_mode,
  output logic pll_fast_lock,
  input wire logic host_bus_sel,
  input wire logic host_cs_n,
  input wire logic host_ds_rd_n,
  input wire logic host_rw_wr_n,
  input wire logic host_mem_sel,
  input wire logic [12:0] host_addr,
  input wire logic [15:0] host_wdata,
  output logic [15:0] host_rdata,
  output logic host_rdata_oe,
  output logic host_ready,
  input wire logic [415:0] ber_det_src,
  input wire logic [31:0] ber_clear,
  output logic [31:0] ber_error
);
  localparam int PW = 103;
  logic [PW-1:0] sync1_q, pin_q;
  logic [10:0] fpos_q, fpos_d;
  logic tick, ext_clk_q, rd_act, wr_act, host_sel;
  logic [4:0] wr_idx_q, wr_idx_d, idx_q, idx_d;
  tsw_eng_state_t st_q, st_d;
  logic [12:0] cm_raddr, dm_raddr;
  logic [15:0] cm_rdata, host_rdata_q, host_rdata_d;
  logic [7:0] dm_rdata, fill_byte;
  logic [31:0] fill_sel, prbs_step, wr_clr;
  logic fill_hiz, fill_any, served_q, served_d, dm_we, cm_we;
  wire [31:0] in_pend, out_need;
  wire [7:0] in_byte [32];
  wire [7:0] in_chan [32];
  wire [7:0] nxt_chan [32];
  wire [7:0] prbs_byte [32];
  wire [3:0] ref_fail;
  tsw_slot_mode_t slot_mode;
  tsw_timing_mode_t tmode, mode_q, mode_d;
  logic [1:0] sel_q, sel_d, alt;

  // Pin synchronisers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_q <= '1;
      pin_q <= '1;
      ext_clk_q <= 1'b1;
    end else if (ce) begin
      sync1_q <= {host_wdata, host_mem_sel, host_addr, host_rw_wr_n, host_ds_rd_n, host_cs_n, ext_frame_pulse,
                  ext_bit_clk, timing_reference_inputs, serial_output_stream_in, serial_input_stream};
      pin_q <= sync1_q;
      ext_clk_q <= pin_q[68];
    end
  end

  // Frame bit position at the 16 Mbps base rate
  always_comb begin
    tick = master_mode ? pll_bit_tick : (pin_q[68] && !ext_clk_q);
    fpos_d = fpos_q;
    if (tick) begin
      fpos_d = (master_mode ? pll_frame_start : pin_q[69]) ? 11'h000 : fpos_q + 11'h001;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fpos_q <= 11'h000;
    end else if (ce) begin
      fpos_q <= fpos_d;
    end
  end

  // Per-stream serial engines
  for (genvar s = 0; s < 32; s++) begin : g_str
    logic [1:0] ir, orr;
    logic [10:0] ibit, obit;
    logic ien, oen, din;
    logic [7:0] ish_q, ish_d, ibyte_q, ibyte_d, ichan_q, ichan_d;
    logic [7:0] osh_q, osh_d, onxt_q, onxt_d, ochan_q, ochan_d;
    logic ipend_q, ipend_d, ohiz_q, ohiz_d, onhiz_q, onhiz_d, oneed_q, oneed_d;
    always_comb begin
      ir = in_rate[2*s +: 2];
      orr = out_rate[2*s +: 2];
      din = bidir_mode ? pin_q[32+s] : pin_q[s];
      ien = tick && ((fpos_q[2:0] & (3'h7 >> ir)) == 3'h0);
      oen = tick && ((fpos_q[2:0] & (3'h7 >> orr)) == 3'h0);
      ibit = fpos_q >> (2'd3 - ir);
      obit = fpos_q >> (2'd3 - orr);
      ish_d = ish_q;
      ibyte_d = ibyte_q;
      ichan_d = ichan_q;
      ipend_d = ipend_q && !wr_clr[s];
      if (ien) begin
        ish_d = {ish_q[6:0], din};
        if (ibit[2:0] == 3'h7) begin
          ibyte_d = {ish_q[6:0], din};
          ichan_d = ibit[10:3];
          ipend_d = 1'b1;
        end
      end
      osh_d = osh_q;
      ohiz_d = ohiz_q;
      ochan_d = ochan_q;
      onxt_d = fill_sel[s] ? fill_byte : onxt_q;
      onhiz_d = fill_sel[s] ? fill_hiz : onhiz_q;
      oneed_d = oneed_q && !fill_sel[s];
      if (oen) begin
        if (obit[2:0] == 3'h0) begin
          osh_d = onxt_q;
          ohiz_d = onhiz_q;
          oneed_d = 1'b1;
          ochan_d = (obit[10:3] + 8'h01) & (8'hff >> (2'd3 - orr));
        end else begin
          osh_d = {osh_q[6:0], 1'b0};
        end
      end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        ish_q <= 8'h00;
        ibyte_q <= 8'h00;
        ichan_q <= 8'h00;
        ipend_q <= 1'b0;
        osh_q <= `TSW_IDLE_BYTE;
        onxt_q <= `TSW_IDLE_BYTE;
        ohiz_q <= 1'b1;
        onhiz_q <= 1'b1;
        oneed_q <= 1'b0;
        ochan_q <= 8'h00;
      end else if (ce) begin
        ish_q <= ish_d;
        ibyte_q <= ibyte_d;
        ichan_q <= ichan_d;
        ipend_q <= ipend_d;
        osh_q <= osh_d;
        onxt_q <= onxt_d;
        ohiz_q <= ohiz_d;
        onhiz_q <= onhiz_d;
        oneed_q <= oneed_d;
        ochan_q <= ochan_d;
      end
    end
    assign in_pend[s] = ipend_q;
    assign in_byte[s] = ibyte_q;
    assign in_chan[s] = ichan_q;
    assign out_need[s] = oneed_q;
    assign nxt_chan[s] = ochan_q;
    assign serial_output_stream_out[s] = osh_q[7];
    assign serial_output_stream_oe[s] = !ohiz_q;
  end

  assign stream_tristate_control = ~serial_output_stream_oe[15:0];

  // Input bytes drain round robin into the data memory
  always_comb begin
    dm_we = in_pend[wr_idx_q];
    wr_clr = dm_we ? (32'h1 << wr_idx_q) : 32'h0;
    wr_idx_d = wr_idx_q + 5'h01;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_idx_q <= 5'h00;
    end else if (ce) begin
      wr_idx_q <= wr_idx_d;
    end
  end

  tsw_ram #(.W(`TSW_DM_W), .AW(`TSW_MEM_AW)) u_dm (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .we(dm_we), .waddr({wr_idx_q, in_chan[wr_idx_q]}),
    .wdata(in_byte[wr_idx_q]), .raddr(dm_raddr), .rdata(dm_rdata)
  );

  tsw_ram #(.W(`TSW_CM_W), .AW(`TSW_MEM_AW)) u_cm (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .we(cm_we), .waddr(pin_q[85:73]),
    .wdata(pin_q[102:87]), .raddr(cm_raddr), .rdata(cm_rdata)
  );

  // Host strobe decode for the two conventions
  always_comb begin
    host_sel = pin_q[86];
    if (host_bus_sel) begin
      rd_act = !pin_q[70] && !pin_q[71] && pin_q[72];
      wr_act = !pin_q[70] && !pin_q[71] && !pin_q[72];
    end else begin
      rd_act = !pin_q[70] && !pin_q[71];
      wr_act = !pin_q[70] && !pin_q[72] && pin_q[71];
    end
    cm_we = wr_act && !served_q && !host_sel;
  end

  // Output fill engine and host read port
  always_comb begin
    slot_mode = tsw_slot_mode_t'(cm_rdata[`TSW_CM_MODE_LSB +: 2]);
    st_d = st_q;
    idx_d = idx_q;
    cm_raddr = {idx_q, nxt_chan[idx_q]};
    dm_raddr = cm_rdata[`TSW_CM_SRC_LSB +: 13];
    fill_any = 1'b0;
    fill_byte = `TSW_IDLE_BYTE;
    fill_hiz = 1'b0;
    prbs_step = 32'h0;
    host_rdata_d = host_rdata_q;
    served_d = served_q && (rd_act || wr_act);
    if (wr_act && !served_q) begin
      served_d = 1'b1;
    end
    case (st_q)
      ST_SCAN: begin
        if (rd_act && !served_q) begin
          cm_raddr = pin_q[85:73];
          dm_raddr = pin_q[85:73];
          st_d = ST_HWAIT;
        end else if (out_need[idx_q]) begin
          st_d = ST_CM;
        end else begin
          idx_d = idx_q + 5'h01;
        end
      end
      ST_CM: begin
        st_d = ST_SCAN;
        idx_d = idx_q + 5'h01;
        case (slot_mode)
          TSW_SLOT_CONN: begin
            st_d = ST_DM;
            idx_d = idx_q;
          end
          TSW_SLOT_MSG: begin
            fill_any = 1'b1;
            fill_byte = cm_rdata[`TSW_CM_MSG_LSB +: 8];
          end
          TSW_SLOT_BER: begin
            fill_any = 1'b1;
            fill_byte = prbs_byte[cm_rdata[`TSW_CM_GEN_LSB +: 5]];
            prbs_step = 32'h1 << cm_rdata[`TSW_CM_GEN_LSB +: 5];
          end
          default: begin
            fill_any = 1'b1;
            fill_hiz = 1'b1;
          end
        endcase
      end
      ST_DM: begin
        fill_any = 1'b1;
        fill_byte = dm_rdata;
        idx_d = idx_q + 5'h01;
        st_d = ST_SCAN;
      end
      default: begin
        host_rdata_d = host_sel ? {8'h00, dm_rdata} : cm_rdata;
        served_d = rd_act;
        st_d = ST_SCAN;
      end
    endcase
    fill_sel = fill_any ? (32'h1 << idx_q) : 32'h0;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= ST_SCAN;
      idx_q <= 5'h00;
      host_rdata_q <= 16'h0000;
      served_q <= 1'b0;
    end else if (ce) begin
      st_q <= st_d;
      idx_q <= idx_d;
      host_rdata_q <= host_rdata_d;
      served_q <= served_d;
    end
  end

  assign host_rdata = host_rdata_q;
  assign host_rdata_oe = rd_act && served_q;
  assign host_ready = served_q && (rd_act || wr_act);

  // Sequence generators and error detectors
  for (genvar g = 0; g < 32; g++) begin : g_ber
    logic [14:0] gen_q, gen_d, hist_q, hist_d;
    logic [22:0] gnx, hnx;
    logic [1:0] lock_q, lock_d;
    logic err_q, err_d, hit;
    always_comb begin
      gnx = tsw_prbs8(gen_q);
      hnx = tsw_prbs8(hist_q);
      gen_d = prbs_step[g] ? gnx[14:0] : gen_q;
      hit = dm_we && ({wr_idx_q, in_chan[wr_idx_q]} == ber_det_src[13*g +: 13]);
      hist_d = hit ? {hist_q[6:0], in_byte[wr_idx_q]} : hist_q;
      lock_d = (hit && lock_q != 2'h2) ? lock_q + 2'h1 : lock_q;
      err_d = (err_q && !ber_clear[g]) || (hit && lock_q == 2'h2 && hnx[22:15] != in_byte[wr_idx_q]);
    end
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        gen_q <= `TSW_PRBS_SEED;
        hist_q <= 15'h0000;
        lock_q <= 2'h0;
        err_q <= 1'b0;
      end else if (ce) begin
        gen_q <= gen_d;
        hist_q <= hist_d;
        lock_q <= lock_d;
        err_q <= err_d;
      end
    end
    assign prbs_byte[g] = gnx[22:15];
    assign ber_error[g] = err_q;
  end

  // Reference activity monitors
  for (genvar r = 0; r < 4; r++) begin : g_ref
    logic last_q, last_d;
    logic [13:0] cnt_q, cnt_d;
    always_comb begin
      last_d = pin_q[64+r];
      cnt_d = (pin_q[64+r] != last_q) ? 14'h0000 : cnt_q;
      if (pin_q[64+r] == last_q && cnt_q < 14'(REF_LOSS_CYCLES)) begin
        cnt_d = cnt_q + 14'h0001;
      end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        last_q <= 1'b0;
        cnt_q <= 14'h0000;
      end else if (ce) begin
        last_q <= last_d;
        cnt_q <= cnt_d;
      end
    end
    assign ref_fail[r] = (cnt_q >= 14'(REF_LOSS_CYCLES));
  end

  assign reference_failure_outputs = (master_mode || slave_pll_enable) ? ref_fail : 4'h0;

  // Loop reference choice and timing mode
  always_comb begin
    tmode = tsw_timing_mode_t'(timing_mode);
    alt = ref_pref + 2'h1;
    sel_d = sel_q;
    mode_d = tmode;
    case (tmode)
      TM_NORMAL: begin
        sel_d = ref_pref;
        mode_d = ref_fail[ref_pref] ? TM_HOLDOVER : TM_NORMAL;
      end
      TM_AUTO: begin
        if (!ref_fail[ref_pref]) begin
          sel_d = ref_pref;
        end else if (!ref_fail[alt]) begin
          sel_d = alt;
        end
        mode_d = (ref_fail[ref_pref] && ref_fail[alt]) ? TM_HOLDOVER : TM_NORMAL;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sel_q <= 2'h0;
      mode_q <= TM_FREERUN;
    end else if (ce) begin
      sel_q <= sel_d;
      mode_q <= mode_d;
    end
  end

  assign pll_ref_sel = sel_q;
  assign pll_mode = mode_q;
  assign pll_ref_level = pin_q[64 + sel_q];
  assign pll_fast_lock = fast_lock && (mode_q != TM_FREERUN);

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst || !ce);

  sequence conn_read_s;
    st_q == ST_CM && slot_mode == TSW_SLOT_CONN;
  endsequence
  sequence host_read_s;
    st_q == ST_SCAN && rd_act && !served_q;
  endsequence

  conn_fill_a: assert property (conn_read_s |=> st_q == ST_DM ##0 (fill_sel[idx_q] && fill_byte == dm_rdata)) else $error("conn slot not filled from data memory");
  msg_fill_a: assert property (st_q == ST_CM && slot_mode == TSW_SLOT_MSG |-> fill_any && !fill_hiz && fill_byte == cm_rdata[7:0]) else $error("message byte not used");
  ber_step_a: assert property (st_q == ST_CM && slot_mode == TSW_SLOT_BER |-> $onehot(prbs_step) && fill_any) else $error("sequence generator not stepped");
  hiz_fill_a: assert property (st_q == ST_CM && slot_mode == TSW_SLOT_HIZ |-> fill_hiz && fill_any) else $error("hiz slot not marked");
  ber_sticky_a: assert property (ber_error[0] && !ber_clear[0] |=> ber_error[0]) else $error("error flag lost");
  tristate_ctl_a: assert property (stream_tristate_control == ~serial_output_stream_oe[15:0]) else $error("tristate control mismatch");
  ref_slave_a: assert property (!master_mode && !slave_pll_enable |-> reference_failure_outputs == 4'h0) else $error("failure output in slave");
  fastlock_a: assert property (mode_q == TM_FREERUN |-> !pll_fast_lock) else $error("fast lock in freerun");
  auto_pair_a: assert property ($past(tmode) == TM_AUTO && $past(ref_fail[ref_pref]) == 1'b0 |-> sel_q == $past(ref_pref)) else $error("preferred ref not chosen");
  host_read_a: assert property (host_read_s |=> st_q == ST_HWAIT ##1 (host_ready || !rd_act)) else $error("host read not answered");
  dm_write_a: assert property (in_pend[wr_idx_q] |=> !in_pend[$past(wr_idx_q)] || $past(wr_clr) != 32'h0) else $error("input byte not stored");
endmodule : tsw_core

// [tsw_regs.svh]
// Constants of the channel switch core: memory layout, entry fields, resets and timing counts
`ifndef TSW_REGS_SVH
`define TSW_REGS_SVH
`define TSW_STREAMS 32
`define TSW_DETECTORS 32
`define TSW_MEM_AW 13
`define TSW_CM_W 16
`define TSW_DM_W 8
`define TSW_CM_MODE_LSB 14
`define TSW_CM_SRC_LSB 0
`define TSW_CM_GEN_LSB 8
`define TSW_CM_MSG_LSB 0
`define TSW_PRBS_SEED 15'h7fff
`define TSW_IDLE_BYTE 8'hff
`define TSW_CLK_NS 20
`define TSW_REF_LOSS_NS 250000
`define TSW_REF_LOSS_CYCLES ((`TSW_REF_LOSS_NS + `TSW_CLK_NS - 1) / `TSW_CLK_NS)
`endif

// [tsw_pkg.sv]
// Types and helpers of the channel switch core
package tsw_pkg;
  typedef enum logic [1:0] {TSW_SLOT_CONN, TSW_SLOT_MSG, TSW_SLOT_BER, TSW_SLOT_HIZ} tsw_slot_mode_t;
  typedef enum logic [1:0] {TM_NORMAL, TM_HOLDOVER, TM_FREERUN, TM_AUTO} tsw_timing_mode_t;
  typedef enum {ST_SCAN, ST_CM, ST_DM, ST_HWAIT} tsw_eng_state_t;

  // Advances a 2^15-1 sequence by eight bits, returns {byte, new state}
  function automatic logic [22:0] tsw_prbs8(input logic [14:0] st);
    logic [14:0] s;
    logic [7:0] b;
    logic fb;
    s = st;
    b = 8'h00;
    for (int i = 0; i < 8; i++) begin
      fb = s[14] ^ s[13];
      s = {s[13:0], fb};
      b = {b[6:0], fb};
    end
    return {b, s};
  endfunction : tsw_prbs8
endpackage : tsw_pkg

// [tsw_ram.sv]
// Simple dual-port memory with registered read data
`timescale 1ns/1ps
module tsw_ram #(
  parameter int W = 8,
  parameter int AW = 13
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);
  logic [W-1:0] mem [2**AW];
  logic [W-1:0] rdata_q;

  always_ff @(posedge clk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= '0;
    end else if (ce) begin
      rdata_q <= mem[raddr];
    end
  end

  assign rdata = rdata_q;
endmodule : tsw_ram

// [tsw_peer.sv]
// Framer model: feeds the serial inputs and captures the serial outputs of the switch
`timescale 1ns/1ps
module tsw_peer (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic tick,
  input wire logic fstart,
  input wire logic corrupt,
  input wire logic [31:0] line,
  input wire logic [31:0] oe,
  input wire logic [15:0] tsc,
  output logic [31:0] din,
  output logic [31:0] bdin
);
  logic [10:0] fpos_q;
  int frame_cnt;
  logic [7:0] cap [32][32];
  logic hz [32][32];
  logic tz [32][32];
  logic [14:0] hist_q;
  logic [7:0] prbs_q;
  function automatic logic [7:0] pat(input int s, input int c);
    return 8'(s * 37 + c * 11 + 33);
  endfunction : pat
  always @(posedge clk or posedge sys_rst) begin : run
    int p;
    int b;
    int q;
    logic [7:0] v;
    logic [14:0] h;
    if (sys_rst) begin
      fpos_q <= '0;
      frame_cnt <= 0;
      din <= '1;
      bdin <= '1;
      hist_q <= 15'h0001;
    end else if (tick) begin
      p = fstart ? 0 : int'(fpos_q) + 1;
      fpos_q <= 11'(p);
      if (fstart) begin
        frame_cnt <= frame_cnt + 1;
        h = hist_q;
        // One byte of a x^15+x^14+1 sequence per frame on stream 4 channel 2
        for (int i = 0; i < 8; i++) begin
          h = {h[13:0], h[14] ^ h[13]};
          prbs_q[7 - i] <= h[0];
        end
        hist_q <= h;
      end
      if (p % 8 == 4) begin
        // Inputs change mid bit, outputs are sampled mid bit
        b = ((p + 4) / 8) % 256;
        q = p / 8;
        for (int s = 0; s < 32; s++) begin
          v = pat(s, b / 8);
          din[s] <= v[7 - b % 8];
          bdin[s] <= ~v[7 - b % 8];
          cap[s][q / 8] <= {cap[s][q / 8][6:0], line[s]};
          hz[s][q / 8] <= (q % 8 == 0 ? 1'b0 : hz[s][q / 8]) | ~oe[s];
          if (s < 16) tz[s][q / 8] <= (q % 8 == 0 ? 1'b0 : tz[s][q / 8]) | tsc[s];
        end
        if (b / 8 == 2) din[4] <= prbs_q[7 - b % 8] ^ (corrupt && b % 8 == 3);
      end
    end
  end
endmodule : tsw_peer

// [tb.sv]
// Self-checking bench of the channel switch core with a framer model
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin failures++; $display("CHECK FAILED at %0t: got %h expected %h", $time, a, e); end end
module tb import tsw_pkg::*;;
  typedef struct packed {logic [4:0] os; logic [4:0] oc; logic [15:0] ent; logic [7:0] exp; logic hiz; logic bus;} tsw_row_t;
  tsw_row_t rows [10] = '{
    '{5'd0, 5'd0, 16'h0105, 8'h7d, 1'b0, 1'b0},
    '{5'd0, 5'd31, 16'h1f00, 8'h9c, 1'b0, 1'b1},
    '{5'd1, 5'd3, 16'h0003, 8'h42, 1'b0, 1'b0},
    '{5'd1, 5'd4, 16'h40a5, 8'ha5, 1'b0, 1'b1},
    '{5'd0, 5'd1, 16'h4000, 8'h00, 1'b0, 1'b0},
    '{5'd2, 5'd6, 16'hc000, 8'h00, 1'b1, 1'b1},
    '{5'd2, 5'd7, 16'hc000, 8'h00, 1'b1, 1'b0},
    '{5'd20, 5'd7, 16'hc000, 8'h00, 1'b1, 1'b1},
    '{5'd5, 5'd9, 16'h0207, 8'hb8, 1'b0, 1'b0},
    '{5'd6, 5'd31, 16'h401f, 8'h1f, 1'b0, 1'b1}};
  int failures = 0;
  int check_count = 0;
  int cyc = 0;
  logic clk = 1'b0, sys_rst = 1'b1, ce = 1'b1, bidir_mode = 1'b0, master_mode = 1'b1, slave_pll_enable = 1'b0;
  logic pll_bit_tick = 1'b0, pll_frame_start = 1'b0, ext_bit_clk = 1'b0, ext_frame_pulse = 1'b0, fast_lock = 1'b0;
  logic host_bus_sel = 1'b0, host_cs_n = 1'b1, host_ds_rd_n = 1'b1, host_rw_wr_n = 1'b1, host_mem_sel = 1'b0;
  logic tick_en = 1'b0, corrupt = 1'b0, pll_ref_level, pll_fast_lock, host_rdata_oe, host_ready;
  logic [1:0] timing_mode = 2'd0, ref_pref = 2'd3, pll_ref_sel, pll_mode, div_q = 2'd0;
  logic [3:0] timing_reference_inputs = 4'h0, reference_failure_outputs;
  logic [10:0] tcnt_q = 11'd0;
  logic [12:0] host_addr = 13'h0000;
  logic [15:0] host_wdata = 16'h0000, host_rdata, stream_tristate_control;
  logic [31:0] serial_input_stream, serial_output_stream_in, serial_output_stream_out, serial_output_stream_oe, bdin;
  logic [31:0] ber_clear = 32'hffffffff, ber_error;
  logic [63:0] in_rate = 64'h0, out_rate = 64'h0;
  logic [415:0] ber_det_src = {32{13'h0402}};
  assign serial_output_stream_in = (serial_output_stream_oe & serial_output_stream_out) | (~serial_output_stream_oe & bdin);
  tsw_core #(.REF_LOSS_CYCLES(40)) tsw_core_inst (.*);
  tsw_peer tsw_peer_inst (.clk(clk), .sys_rst(sys_rst), .tick(pll_bit_tick), .fstart(pll_frame_start),
    .corrupt(corrupt), .line(serial_output_stream_out), .oe(serial_output_stream_oe),
    .tsc(stream_tristate_control), .din(serial_input_stream), .bdin(bdin));
  task automatic complete_run();
    if (failures == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run
  task automatic host_io(input logic bus, input logic wr, input logic mem, input logic [12:0] a,
                         input logic [15:0] wd, output logic [15:0] rd);
    int n;
    @(posedge clk);
    host_bus_sel <= bus;
    host_mem_sel <= mem;
    host_addr <= a;
    host_wdata <= wd;
    host_rw_wr_n <= !wr;
    @(posedge clk);
    host_cs_n <= 1'b0;
    host_ds_rd_n <= bus ? 1'b0 : wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (host_ready !== 1'b1 && n < 40);
    rd = host_rdata;
    `CHK(host_ready, 1'b1)
    `CHK(host_rdata_oe, !wr)
    host_cs_n <= 1'b1;
    host_ds_rd_n <= 1'b1;
    host_rw_wr_n <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (host_ready !== 1'b0 && n < 40);
    repeat (3) @(posedge clk);
  endtask : host_io
  task automatic wait_frame(input int n);
    wait (tsw_peer_inst.frame_cnt >= n);
    #1;
  endtask : wait_frame
  initial begin
    forever #10 clk = ~clk;
  end
  // Base ticks from the timing loop, a junk external clock and three live references
  always @(posedge clk) begin
    cyc++;
    ext_bit_clk <= ~ext_bit_clk;
    timing_reference_inputs <= {1'b0, {3{cyc[3]}}};
    if (tick_en) begin
      div_q <= div_q + 2'd1;
      pll_bit_tick <= div_q == 2'd3;
      pll_frame_start <= div_q == 2'd3 && tcnt_q == 11'd0;
      if (div_q == 2'd3) tcnt_q <= tcnt_q + 11'd1;
    end
    if (cyc == 90000) begin
      failures++;
      complete_run();
    end
  end
  initial begin : main
    logic [15:0] rd;
    logic [23:0] pb;
    logic [23:0] ex;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (rows[i]) host_io(rows[i].bus, 1'b1, 1'b0, {rows[i].os, 3'b000, rows[i].oc}, rows[i].ent, rd);
    host_io(1'b0, 1'b1, 1'b0, {5'd3, 8'd0}, 16'h8500, rd);
    `CHK(reference_failure_outputs, 4'b1000)
    `CHK(pll_ref_sel, 2'd3)
    `CHK(pll_mode, TM_HOLDOVER)
    timing_mode <= 2'd3;
    repeat (8) @(posedge clk);
    `CHK(pll_ref_sel, 2'd0)
    timing_mode <= 2'd2;
    fast_lock <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK(pll_mode, TM_FREERUN)
    `CHK(pll_fast_lock, 1'b0)
    timing_mode <= 2'd0;
    repeat (8) @(posedge clk);
    `CHK(pll_fast_lock, 1'b1)
    `CHK(pll_ref_level, 1'b0)
    fast_lock <= 1'b0;
    tick_en <= 1'b1;
    wait_frame(3);
    foreach (rows[i]) begin
      `CHK(tsw_peer_inst.hz[rows[i].os][rows[i].oc], rows[i].hiz)
      if (!rows[i].hiz) `CHK(tsw_peer_inst.cap[rows[i].os][rows[i].oc], rows[i].exp)
      if (rows[i].os < 16) `CHK(tsw_peer_inst.tz[rows[i].os][rows[i].oc], rows[i].hiz)
    end
    pb = {16'h0000, tsw_peer_inst.cap[3][0]};
    ber_clear <= 32'h0;
    host_io(1'b0, 1'b0, 1'b1, {5'd1, 8'd5}, 16'h0000, rd);
    `CHK(rd, 16'h007d)
    host_io(1'b1, 1'b1, 1'b1, {5'd1, 8'd5}, 16'h1234, rd);
    host_io(1'b1, 1'b0, 1'b1, {5'd1, 8'd5}, 16'h0000, rd);
    `CHK(rd, 16'h007d)
    host_io(1'b1, 1'b0, 1'b0, {5'd1, 8'd4}, 16'h0000, rd);
    `CHK(rd, 16'h40a5)
    wait_frame(4);
    pb = {pb[15:0], tsw_peer_inst.cap[3][0]};
    wait_frame(5);
    pb = {pb[15:0], tsw_peer_inst.cap[3][0]};
    ex = pb;
    for (int n = 15; n < 24; n++) ex[23 - n] = pb[38 - n] ^ pb[37 - n];
    `CHK(pb, ex)
    `CHK(pb == 24'h0, 1'b0)
    `CHK(ber_error, 32'h0)
    corrupt <= 1'b1;
    wait_frame(6);
    corrupt <= 1'b0;
    `CHK(ber_error, 32'hffffffff)
    ber_clear <= 32'hffffffff;
    @(posedge clk);
    ber_clear <= 32'h0;
    repeat (3) @(posedge clk);
    `CHK(ber_error, 32'h0)
    bidir_mode <= 1'b1;
    wait_frame(8);
    `CHK(tsw_peer_inst.cap[5][9], 8'h47)
    // Stream 1 input at 16 Mbps: its channel 5 holds two 2 Mbps bits that are both ones
    bidir_mode <= 1'b0;
    in_rate <= 64'hc;
    wait_frame(10);
    `CHK(tsw_peer_inst.cap[0][0], 8'hff)
    master_mode <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK(reference_failure_outputs, 4'h0)
    slave_pll_enable <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK(reference_failure_outputs, 4'b1000)
    complete_run();
  end
endmodule : tb
